// file: tpw_map.svh
`ifndef TPW_MAP_SVH
`define TPW_MAP_SVH
// register word addresses on the plain port
`define TPW_ADDR_W          4
`define TPW_REG_DUTY_A      4'h0
`define TPW_REG_DUTY_B      4'h1
`define TPW_REG_DUTY_C      4'h2
`define TPW_REG_PERIOD      4'h3
`define TPW_REG_DEAD        4'h4
`define TPW_REG_MIN_PULSE   4'h5
`define TPW_REG_SEG         4'h6
`define TPW_REG_GATE        4'h7
`define TPW_REG_CTRL        4'h8
`define TPW_REG_STATUS      4'h9
// output segment control fields
`define TPW_SEG_W           9
`define TPW_SEG_XOVER_A     8
`define TPW_SEG_XOVER_B     7
`define TPW_SEG_XOVER_C     6
`define TPW_SEG_DIS_CH      0
`define TPW_SEG_DIS_CL      1
`define TPW_SEG_DIS_BH      2
`define TPW_SEG_DIS_BL      3
`define TPW_SEG_DIS_AH      4
`define TPW_SEG_DIS_AL      5
`define TPW_SEG_RESET       9'h000
// gate chop control fields
`define TPW_GATE_W          10
`define TPW_GATE_CHOP_HI    8
`define TPW_GATE_CHOP_LO    9
`define TPW_GATE_RESET      10'h000
// control register: bit 0 run, bit 1 double update
`define TPW_CTRL_RUN        0
`define TPW_CTRL_DOUBLE     1
`define TPW_CTRL_RESET      2'h0
`define TPW_DATA_RESET      16'h0000
`endif

// file: tpw_pkg.sv
package tpw_pkg;
  typedef enum logic {TPW_HALF_FIRST, TPW_HALF_SECOND} tpw_half_e;
  typedef logic [15:0] tpw_word_t;
endpackage

// file: tpw_chop_gen.sv
`include "tpw_map.svh"
module tpw_chop_gen
  import tpw_pkg::*;
#(
  parameter int DIV_W = 8
) (
  // clock and reset
  input  wire logic             sys_clk_in,
  input  wire logic             sys_rst_in,
  // control
  input  wire logic             enable_in,
  input  wire logic [DIV_W-1:0] divider_in,
  // carrier
  output logic                  carrier_out
);
  // carrier toggles every 2*(div+1) clocks: period 4*(div+1)
  logic [DIV_W:0] count;
  wire  [DIV_W:0] half_len = {divider_in, 1'b1};
  wire            wrap     = (count == half_len);

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || !enable_in) begin
      count       <= '0;
      carrier_out <= 1'b0;
    end else begin
      count       <= wrap ? '0 : count + 1'b1;
      carrier_out <= wrap ? ~carrier_out : carrier_out;
    end
  end
endmodule

// file: tpw_output_stage.sv
// Function
// - single update: same duty both halves
// - double update: separate duty per half
// - minimum on-time equals register times clock
// - short on-time: off, complement fully on
// - segment register nine bits, crossover 8/7/6
// - crossover swaps high and low routing
// - reset clears crossover bits
// - disable bits 0..5 force outputs off
// - phase C disables at bits 0,1
// - disable applied after crossover
// - reset clears disable bits
// - segment latched on sync edge
// - gate bits 8/9 chop high/low sides
// - divider bits 0..7, period four(div+1)
// - reset clears gate chop register
// - double update adds mid-period sync
// - duty is high on-time, dead-time adjusted
//
// Chosen here: the plain strobed port and the register offsets.
`include "tpw_map.svh"
module tpw_output_stage
  import tpw_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // clock and reset
  input  wire logic                   sys_clk_in,
  input  wire logic                   sys_rst_in,
  // register port
  input  wire logic [`TPW_ADDR_W-1:0] reg_addr_in,
  input  wire logic [15:0]            reg_wdata_in,
  input  wire logic                   reg_wr_in,
  input  wire logic                   reg_rd_in,
  output logic      [15:0]            reg_rdata_out,
  // sync
  output logic                        period_sync_pulse_out,
  // gate drive outputs, high = on
  output logic                        phase_a_high_out,
  output logic                        phase_a_low_out,
  output logic                        phase_b_high_out,
  output logic                        phase_b_low_out,
  output logic                        phase_c_high_out,
  output logic                        phase_c_low_out
);
  // shadow registers written by software
  logic [CNT_W-1:0]       duty_phase_a, duty_phase_b, duty_phase_c;
  logic [CNT_W-1:0]       period_reg, dead_time_reg, min_pulse_width_reg;
  logic [`TPW_SEG_W-1:0]  output_segment_control;
  logic [`TPW_GATE_W-1:0] gate_chop_control;
  logic [1:0]             ctrl;
  // active copies latched at sync
  logic [CNT_W-1:0]       act_duty [3];
  logic [CNT_W-1:0]       act_period, act_dead, act_min;
  logic [`TPW_SEG_W-1:0]  act_seg;
  logic                   act_double;
  logic [CNT_W-1:0]       count;
  tpw_half_e              half;
  logic [2:0]             hi_on, lo_on;

  wire run      = ctrl[`TPW_CTRL_RUN];
  wire half_end = (count == act_period - 1'b1) || (act_period == '0);
  // sync at period start, and at mid-period only in double update
  wire sync_now = run && half_end && (half == TPW_HALF_SECOND || act_double);

  // dead-time adjusted half-period on-time, saturating at zero
  function automatic logic [CNT_W-1:0] sub_sat(input logic [CNT_W-1:0] a,
                                               input logic [CNT_W-1:0] b);
    sub_sat = (a > b) ? a - b : '0;
  endfunction

  // center-based on window: on while count lies in the centered span
  function automatic logic in_window(input logic [CNT_W-1:0] cnt,
                                     input logic [CNT_W-1:0] per,
                                     input logic [CNT_W-1:0] on_t,
                                     input tpw_half_e        h);
    // first half: on at its end; second half: on at its start
    if (h == TPW_HALF_FIRST)
      in_window = ({1'b0, cnt} + {1'b0, on_t} >= {1'b0, per});
    else
      in_window = (cnt < on_t);
  endfunction

  // write enables, one per register except status
  function automatic logic wr_hit(input logic [`TPW_ADDR_W-1:0] a);
    wr_hit = reg_wr_in && (reg_addr_in == a);
  endfunction

  wire wr_duty_a = wr_hit(`TPW_REG_DUTY_A);
  wire wr_duty_b = wr_hit(`TPW_REG_DUTY_B);
  wire wr_duty_c = wr_hit(`TPW_REG_DUTY_C);
  wire wr_period = wr_hit(`TPW_REG_PERIOD);
  wire wr_dead   = wr_hit(`TPW_REG_DEAD);
  wire wr_min    = wr_hit(`TPW_REG_MIN_PULSE);
  wire wr_seg    = wr_hit(`TPW_REG_SEG);
  wire wr_gate   = wr_hit(`TPW_REG_GATE);
  wire wr_ctrl   = wr_hit(`TPW_REG_CTRL);

  // shadow registers; writes to unmapped addresses fall through
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in)
      duty_phase_a <= '0;
    else if (wr_duty_a)
      duty_phase_a <= reg_wdata_in[CNT_W-1:0];
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in)
      duty_phase_b <= '0;
    else if (wr_duty_b)
      duty_phase_b <= reg_wdata_in[CNT_W-1:0];
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in)
      duty_phase_c <= '0;
    else if (wr_duty_c)
      duty_phase_c <= reg_wdata_in[CNT_W-1:0];
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in)
      period_reg <= '0;
    else if (wr_period)
      period_reg <= reg_wdata_in[CNT_W-1:0];
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in)
      dead_time_reg <= '0;
    else if (wr_dead)
      dead_time_reg <= reg_wdata_in[CNT_W-1:0];
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in)
      min_pulse_width_reg <= '0;
    else if (wr_min)
      min_pulse_width_reg <= reg_wdata_in[CNT_W-1:0];
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in)
      output_segment_control <= `TPW_SEG_RESET;
    else if (wr_seg)
      output_segment_control <= reg_wdata_in[`TPW_SEG_W-1:0];
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in)
      gate_chop_control <= `TPW_GATE_RESET;
    else if (wr_gate)
      gate_chop_control <= reg_wdata_in[`TPW_GATE_W-1:0];
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in)
      ctrl <= `TPW_CTRL_RESET;
    else if (wr_ctrl)
      ctrl <= reg_wdata_in[1:0];
  end

  // read mux, data one cycle after the strobe
  logic [15:0] next_rdata;
  always_comb begin
    next_rdata = '0;
    unique case (reg_addr_in)
      `TPW_REG_DUTY_A:    next_rdata = 16'(duty_phase_a);
      `TPW_REG_DUTY_B:    next_rdata = 16'(duty_phase_b);
      `TPW_REG_DUTY_C:    next_rdata = 16'(duty_phase_c);
      `TPW_REG_PERIOD:    next_rdata = 16'(period_reg);
      `TPW_REG_DEAD:      next_rdata = 16'(dead_time_reg);
      `TPW_REG_MIN_PULSE: next_rdata = 16'(min_pulse_width_reg);
      `TPW_REG_SEG:       next_rdata = {7'h00, output_segment_control};
      `TPW_REG_GATE:      next_rdata = {6'h00, gate_chop_control};
      `TPW_REG_CTRL:      next_rdata = {14'h0000, ctrl};
      `TPW_REG_STATUS:    next_rdata = {15'h0000, half == TPW_HALF_SECOND};
      default:            next_rdata = '0;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in)
      reg_rdata_out <= `TPW_DATA_RESET;
    else
      reg_rdata_out <= reg_rd_in ? next_rdata : `TPW_DATA_RESET;
  end

  // half-period timer and latching of settings
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || !run) begin
      count      <= '0;
      half       <= TPW_HALF_SECOND;
      act_duty   <= '{default: '0};
      act_period <= '0;
      act_dead   <= '0;
      act_min    <= '0;
      act_seg    <= `TPW_SEG_RESET;
      act_double <= 1'b0;
    end else if (half_end) begin
      count <= '0;
      half  <= (half == TPW_HALF_FIRST) ? TPW_HALF_SECOND : TPW_HALF_FIRST;
      // single update keeps first-half values for the second half
      if (sync_now) begin
        act_duty   <= '{duty_phase_a, duty_phase_b, duty_phase_c};
        act_period <= period_reg;
        act_dead   <= dead_time_reg;
        act_min    <= min_pulse_width_reg;
        act_seg    <= output_segment_control;
        act_double <= ctrl[`TPW_CTRL_DOUBLE];
      end
    end else begin
      count <= count + 1'b1;
    end
  end

  // timing unit: per phase on-times and pulse deletion
  logic [2:0] next_hi, next_lo;
  always_comb begin
    logic [CNT_W-1:0] t_hi;
    logic [CNT_W-1:0] t_lo;
    t_hi = '0;
    t_lo = '0;
    for (int p = 0; p < 3; p++) begin
      t_hi = sub_sat(act_duty[p], act_dead);
      t_lo = sub_sat(sub_sat(act_period, act_duty[p]), act_dead);
      next_hi[p] = in_window(count, act_period, t_hi, half);
      next_lo[p] = in_window(count, act_period, t_lo, tpw_half_e'(~half));
      // short pulses removed for the half; complement held on
      if (t_hi < act_min) begin
        next_hi[p] = 1'b0;
        next_lo[p] = 1'b1;
      end else if (t_lo < act_min) begin
        next_lo[p] = 1'b0;
        next_hi[p] = 1'b1;
      end
      // nothing is driven until a period has been latched
      if (!run || act_period == '0) begin
        next_hi[p] = 1'b0;
        next_lo[p] = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      hi_on <= '0;
      lo_on <= '0;
    end else begin
      hi_on <= next_hi;
      lo_on <= next_lo;
    end
  end

  // output control: crossover then disable, index 0=A 1=B 2=C
  wire [2:0] xover = {act_seg[`TPW_SEG_XOVER_C], act_seg[`TPW_SEG_XOVER_B],
                      act_seg[`TPW_SEG_XOVER_A]};
  wire [2:0] dis_hi = {act_seg[`TPW_SEG_DIS_CH], act_seg[`TPW_SEG_DIS_BH],
                       act_seg[`TPW_SEG_DIS_AH]};
  wire [2:0] dis_lo = {act_seg[`TPW_SEG_DIS_CL], act_seg[`TPW_SEG_DIS_BL],
                       act_seg[`TPW_SEG_DIS_AL]};
  wire [2:0] rt_hi  = (xover & lo_on) | (~xover & hi_on);
  wire [2:0] rt_lo  = (xover & hi_on) | (~xover & lo_on);
  wire [2:0] en_hi  = rt_hi & ~dis_hi;
  wire [2:0] en_lo  = rt_lo & ~dis_lo;

  // gate drive chopping, settings expected static while running
  logic carrier;
  wire  chop_hi = gate_chop_control[`TPW_GATE_CHOP_HI];
  wire  chop_lo = gate_chop_control[`TPW_GATE_CHOP_LO];
  tpw_chop_gen #(
    .DIV_W (8)
  ) u_chop (
    .sys_clk_in  (sys_clk_in),
    .sys_rst_in  (sys_rst_in),
    .enable_in   (chop_hi | chop_lo),
    .divider_in  (gate_chop_control[7:0]),
    .carrier_out (carrier)
  );
  wire [2:0] fin_hi = en_hi & {3{~chop_hi | carrier}};
  wire [2:0] fin_lo = en_lo & {3{~chop_lo | carrier}};

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      phase_a_high_out      <= 1'b0;
      phase_a_low_out       <= 1'b0;
      phase_b_high_out      <= 1'b0;
      phase_b_low_out       <= 1'b0;
      phase_c_high_out      <= 1'b0;
      phase_c_low_out       <= 1'b0;
      period_sync_pulse_out <= 1'b0;
    end else begin
      phase_a_high_out      <= fin_hi[0];
      phase_a_low_out       <= fin_lo[0];
      phase_b_high_out      <= fin_hi[1];
      phase_b_low_out       <= fin_lo[1];
      phase_c_high_out      <= fin_hi[2];
      phase_c_low_out       <= fin_lo[2];
      period_sync_pulse_out <= sync_now;
    end
  end
endmodule

// file: tpw_output_monitor.sv
`include "tpw_map.svh"
module tpw_output_monitor (
  // clock and reset
  input wire logic                   sys_clk_in,
  input wire logic                   sys_rst_in,
  // register port
  input wire logic [`TPW_ADDR_W-1:0] reg_addr_in,
  input wire logic [15:0]            reg_wdata_in,
  input wire logic                   reg_wr_in,
  input wire logic                   reg_rd_in,
  input wire logic [15:0]            reg_rdata_out,
  // sync and gate outputs
  input wire logic                   period_sync_pulse_out,
  input wire logic                   phase_a_high_out,
  input wire logic                   phase_a_low_out,
  input wire logic                   phase_b_high_out,
  input wire logic                   phase_b_low_out,
  input wire logic                   phase_c_high_out,
  input wire logic                   phase_c_low_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  a_pair_excl_a: assert property (!(phase_a_high_out && phase_a_low_out))
    else $error("phase a pair both on");
  b_pair_excl_a: assert property (!(phase_b_high_out && phase_b_low_out))
    else $error("phase b pair both on");
  c_pair_excl_a: assert property (!(phase_c_high_out && phase_c_low_out))
    else $error("phase c pair both on");
  release_off_a: assert property ($fell(sys_rst_in) |->
    {period_sync_pulse_out, phase_a_high_out, phase_a_low_out, phase_b_high_out,
     phase_b_low_out, phase_c_high_out, phase_c_low_out} == 7'h00)
    else $error("outputs active right after reset");
  sync_single_a: assert property (period_sync_pulse_out |=> !period_sync_pulse_out)
    else $error("sync pulse longer than one cycle");
  seg_readback_a: assert property (reg_wr_in && reg_addr_in == `TPW_REG_SEG ##2
    reg_rd_in && reg_addr_in == `TPW_REG_SEG |=>
    reg_rdata_out == ($past(reg_wdata_in, 3) & 16'h01FF))
    else $error("segment readback wrong");
  gate_readback_a: assert property (reg_wr_in && reg_addr_in == `TPW_REG_GATE ##2
    reg_rd_in && reg_addr_in == `TPW_REG_GATE |=>
    reg_rdata_out == ($past(reg_wdata_in, 3) & 16'h03FF))
    else $error("gate chop readback wrong");
  rdata_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 16'h0000)
    else $error("read data without read");
endmodule

// file: tpw_gate_drv_model.sv
module tpw_gate_drv_model (
  // clock and control
  input wire logic             sys_clk_in,
  input wire logic             clear_in,
  // gate commands, bit 5 phase a high down to bit 0 phase c low
  input wire logic [5:0]       gate_in,
  // on-time seen by each switch
  output logic     [5:0][15:0] on_cnt_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // each switch integrates how long its gate is commanded on
  always_ff @(posedge sys_clk_in)
    for (int i = 0; i < 6; i++)
      on_cnt_out[i] <= clear_in ? 16'h0000 : on_cnt_out[i] + 16'(gate_in[i]);
endmodule

// file: three_phase_pwm_output_stage_tb.sv
`include "tpw_map.svh"
module three_phase_pwm_output_stage_tb import tpw_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   sys_clk_in, sys_rst_in, reg_wr_in, reg_rd_in, clr;
  logic [`TPW_ADDR_W-1:0] reg_addr_in;
  tpw_word_t              reg_wdata_in, reg_rdata_out;
  logic                   period_sync_pulse_out, phase_a_high_out, phase_a_low_out;
  logic                   phase_b_high_out, phase_b_low_out, phase_c_high_out, phase_c_low_out;
  logic [5:0][15:0]       cnt;
  int                     err_count, comparisons;
  // on-counts over two periods, index 0 phase c low up to 5 phase a high
  tpw_word_t exp_on [4][6] = '{'{16'h001C, 16'h0004, 16'h000C, 16'h0014, 16'h0014, 16'h000C},
    '{16'h0028, 16'h0000, 16'h000C, 16'h0014, 16'h0014, 16'h000C},
    '{16'h0000, 16'h0000, 16'h0014, 16'h0000, 16'h0000, 16'h000C},
    '{16'h0000, 16'h0028, 16'h0014, 16'h000C, 16'h000C, 16'h0014}};
  tpw_word_t mins [4] = '{16'h0000, 16'h0002, 16'h0002, 16'h0002};
  tpw_word_t segs [4] = '{16'h0000, 16'h0000, 16'h00A7, 16'h01C0};
  tpw_word_t chop [2] = '{16'h0101, 16'h0201};
  tpw_word_t exp_ch [2][6] = '{'{16'h0028, '0, '0, '0, '0, 16'h0014},
    '{16'h0014, '0, '0, '0, '0, 16'h0028}};

  tpw_output_stage #(.CNT_W(16)) i_tpw_output_stage (.sys_clk_in, .sys_rst_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .period_sync_pulse_out,
    .phase_a_high_out, .phase_a_low_out, .phase_b_high_out, .phase_b_low_out,
    .phase_c_high_out, .phase_c_low_out);
  tpw_gate_drv_model i_tpw_gate_drv_model (.sys_clk_in, .clear_in(clr), .on_cnt_out(cnt),
    .gate_in({phase_a_high_out, phase_a_low_out, phase_b_high_out, phase_b_low_out,
              phase_c_high_out, phase_c_low_out}));

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string name, input tpw_word_t seen, input tpw_word_t exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input tpw_word_t d);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'h1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'h0;
    @(posedge sys_clk_in);
  endtask
  task automatic rd(input logic [3:0] a, input tpw_word_t e, input string n);
    reg_addr_in <= a;
    reg_rd_in   <= 1'h1;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'h0;
    @(posedge sys_clk_in);
    check(n, reg_rdata_out, e);
  endtask
  task automatic wait_sync();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (period_sync_pulse_out !== 1'h1 && n < 200);
    if (period_sync_pulse_out !== 1'h1) begin
      err_count++;
      give_verdict();
    end
  endtask
  // settles new shadow values, then counts on-time over two periods
  task automatic measure(input tpw_word_t e [6], input logic [5:0] m);
    repeat (3) wait_sync();
    clr <= 1'h1;
    @(posedge sys_clk_in);
    clr <= 1'h0;
    repeat (41) @(posedge sys_clk_in);
    for (int i = 0; i < 6; i++)
      if (m[i]) check($sformatf("on_count%0d", i), cnt[i], e[i]);
  endtask
  task automatic sync_count(input tpw_word_t e);
    tpw_word_t n;
    repeat (3) wait_sync();
    n = 16'h0000;
    repeat (40) begin
      @(posedge sys_clk_in);
      n = n + 16'(period_sync_pulse_out);
    end
    check("sync_count", n, e);
  endtask
  function automatic logic chopped_pin(input logic lo_side);
    chopped_pin = lo_side ? phase_c_low_out : phase_a_high_out;
  endfunction
  // length of one carrier-on run on a fully-on chopped output
  task automatic chop_run(input logic lo_side, input tpw_word_t e);
    tpw_word_t n;
    n = 16'h0000;
    for (int k = 0; k < 600 && chopped_pin(lo_side) !== 1'h0; k++) @(posedge sys_clk_in);
    for (int k = 0; k < 600 && chopped_pin(lo_side) !== 1'h1; k++) @(posedge sys_clk_in);
    for (int k = 0; k < 600 && chopped_pin(lo_side) === 1'h1; k++) begin
      @(posedge sys_clk_in);
      n++;
    end
    check("chop_on_run", n, e);
  endtask

  initial begin
    sys_clk_in = 1'h0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    {err_count, comparisons} = '0;
    {sys_rst_in, reg_wr_in, reg_rd_in, clr} = 4'h8;
    reg_addr_in = '0;
    reg_wdata_in = '0;
    repeat (8) @(posedge sys_clk_in);
    sys_rst_in <= 1'h0;
    rd(`TPW_REG_SEG, 16'h0000, "seg_reset");
    rd(`TPW_REG_GATE, 16'h0000, "gate_reset");
    rd(4'hF, 16'h0000, "unmapped");
    wr(`TPW_REG_SEG, 16'hFFFF);
    rd(`TPW_REG_SEG, 16'h01FF, "seg_width");
    wr(`TPW_REG_GATE, 16'hFFFF);
    rd(`TPW_REG_GATE, 16'h03FF, "gate_width");
    wr(`TPW_REG_SEG, 16'h0000);
    wr(`TPW_REG_GATE, 16'h0000);
    wr(`TPW_REG_PERIOD, 16'h000A);
    wr(`TPW_REG_DEAD, 16'h0001);
    wr(`TPW_REG_DUTY_A, 16'h0004);
    wr(`TPW_REG_DUTY_B, 16'h0006);
    wr(`TPW_REG_DUTY_C, 16'h0002);
    wr(`TPW_REG_CTRL, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      wr(`TPW_REG_MIN_PULSE, mins[i]);
      wr(`TPW_REG_SEG, segs[i]);
      measure(exp_on[i], 6'h3F);
    end
    sync_count(16'h0002);
    wr(`TPW_REG_CTRL, 16'h0003);
    sync_count(16'h0004);
    measure(exp_on[3], 6'h3F);
    wr(`TPW_REG_SEG, 16'h0000);
    wr(`TPW_REG_MIN_PULSE, 16'h0000);
    wr(`TPW_REG_DEAD, 16'h0000);
    wr(`TPW_REG_DUTY_A, 16'h000A);
    wr(`TPW_REG_DUTY_C, 16'h0000);
    for (int i = 0; i < 2; i++) begin
      wr(`TPW_REG_CTRL, 16'h0000);
      wr(`TPW_REG_GATE, chop[i]);
      wr(`TPW_REG_CTRL, 16'h0001);
      measure(exp_ch[i], 6'h21);
      chop_run(i[0], 16'h0004);
    end
    give_verdict();
  end
endmodule

bind tpw_output_stage tpw_output_monitor i_tpw_output_monitor (.sys_clk_in, .sys_rst_in,
  .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .period_sync_pulse_out,
  .phase_a_high_out, .phase_a_low_out, .phase_b_high_out, .phase_b_low_out,
  .phase_c_high_out, .phase_c_low_out);
